// *** rtl/maf_pkg.sv ***
// Constants and command encodings for the multi-drop address filter.
// Assumes a command decoder upstream that presents one command code per pulse.
`default_nettype none
package maf_pkg;
   localparam logic [7:0] ADDR_UNASSIGNED = 8'hFF;
   localparam logic [7:0] MASK_ALL = 8'hFF;
   localparam logic [7:0] MASK_NONE = 8'h00;
   localparam logic [7:0] HEX_DIGIT_A = 8'h41;
   localparam logic [7:0] HEX_DIGIT_0 = 8'h30;
   localparam logic [3:0] HEX_TEN = 4'hA;
   typedef enum logic [3:0] {
      MAF_CMD_NONE,
      MAF_CMD_HOLD_ENTRY,
      MAF_CMD_LISTEN,
      MAF_CMD_KILL,
      MAF_CMD_GLOBAL,
      MAF_CMD_MASK,
      MAF_CMD_RESTORE,
      MAF_CMD_SET_ADDR,
      MAF_CMD_SAVE,
      MAF_CMD_SET_OUT,
      MAF_CMD_CLR_OUT,
      MAF_CMD_TOGGLE_OUT,
      MAF_CMD_OPEN_DRAIN,
      MAF_CMD_PUSH_PULL,
      MAF_CMD_REPORT,
      MAF_CMD_OTHER
   } maf_cmd_t;
endpackage
`default_nettype wire

// *** rtl/maf_address_filter.sv ***
// Address filter, listen/ignore state and spare output pin of one drop.
// Assumes a parser on ref_clk_i delivering one-cycle command strobes and a
// nonvolatile store whose contents are presented on stored_addr_i.
//
// Behaviour
// (RL1) With no address configured the unit executes every command.
// (RL2) The unit holds one eight-bit address out of 256 values.
// (RL3) Listening units execute commands; ignoring units do not.
// (RL4) An unassigned stored address reads as all ones.
// (RL5) Info and version reports carry the address as hex text.
// (RL6) Set-address copies holding value into pending register only.
// (RL7) Pending address becomes device address on the save command.
// (RL8) Host keeps only one unit listening while assigning addresses.
// (RL9) Listen command sets listen only when stored address matches.
// (RL10) Kill command sets ignore only when stored address matches.
// (RL11) Holding entries, listen and kill act whatever the state.
// (RL12) Global saves state then forces listen.
// (RL13) Mask saves state then forces ignore.
// (RL14) Restore returns the saved listen or ignore state.
// (RL15) Effective listen or kill also overwrites the saved state.
// (RL16) Second write-clock line doubles as general-purpose output.
// (RL17) Set-output drives pin high, clear-output drives it low.
// (RL18) Toggle-output inverts the pin level.
// (RL19) Pin is open drain or push-pull as last selected.
// (RL20) Global loads the address mask with all ones.
// (RL21) Ignoring units track holding register but give no action.
`default_nettype none
module maf_address_filter
   import maf_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   // Command stream
   input wire logic cmd_valid_i,
   input wire maf_cmd_t cmd_code_i,
   input wire logic [7:0] hold_value_i,
   // Stored configuration
   input wire logic addr_assigned_i,
   input wire logic [7:0] stored_addr_i,
   input wire logic single_synth_i,
   // Execution gate and status
   output logic exec_o,
   output logic listening_o,
   output logic [7:0] device_addr_o,
   output logic [7:0] pending_addr_o,
   output logic [7:0] addr_mask_o,
   output logic save_store_o,
   output logic [15:0] addr_text_o,
   // Spare output pin
   output logic spare_output_port_bit_o,
   output logic spare_output_port_bit_oe_o
);
   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   logic listening, next_listening;
   logic saved, next_saved;
   logic [7:0] dev_addr, next_dev_addr;
   logic [7:0] pending, next_pending;
   logic [7:0] mask, next_mask;
   logic exec, next_exec;
   logic save_pulse, next_save_pulse;
   logic [15:0] text, next_text;
   logic pin_level, next_pin_level;
   logic open_drain, next_open_drain;
   logic pin_oe, next_pin_oe;
   logic loaded;
   logic match;
   logic active;

   function automatic logic [7:0] hex_char(input logic [3:0] n);
      hex_char = (n < HEX_TEN) ? HEX_DIGIT_0 + {4'h0, n}
                               : HEX_DIGIT_A + {4'h0, n - HEX_TEN};
   endfunction

   assign match = (stored_addr_i == hold_value_i); // RL9
   // Unconfigured units always execute, listening or not
   assign active = !addr_assigned_i || listening; // RL1 RL3 RL21

   // -----------------------------------------------------------------
   // Next-state logic
   // -----------------------------------------------------------------
   always_comb begin
      next_listening = listening;
      next_saved = saved;
      next_dev_addr = dev_addr;
      next_pending = pending;
      next_mask = mask;
      next_exec = 1'b0;
      next_save_pulse = 1'b0;
      next_pin_level = pin_level;
      next_open_drain = open_drain;
      next_text = {hex_char(dev_addr[7:4]), hex_char(dev_addr[3:0])}; // RL5
      if (!loaded) begin
         next_dev_addr = addr_assigned_i ? stored_addr_i : ADDR_UNASSIGNED; // RL2 RL4
         next_pending = next_dev_addr;
      end else if (cmd_valid_i) begin
         case (cmd_code_i)
            MAF_CMD_HOLD_ENTRY: begin
               next_exec = 1'b0; // RL11
            end
            MAF_CMD_LISTEN: begin
               if (match) begin
                  next_listening = 1'b1; // RL9 RL11
                  next_saved = 1'b1; // RL15
                  next_mask = MASK_ALL;
               end
            end
            MAF_CMD_KILL: begin
               if (match) begin
                  next_listening = 1'b0; // RL10 RL11
                  next_saved = 1'b0; // RL15
                  next_mask = MASK_NONE;
               end
            end
            MAF_CMD_GLOBAL: begin
               next_saved = listening; // RL12
               next_listening = 1'b1; // RL12
               next_mask = MASK_ALL; // RL20
            end
            MAF_CMD_MASK: begin
               next_saved = listening; // RL13
               next_listening = 1'b0; // RL13
               next_mask = MASK_NONE;
            end
            MAF_CMD_RESTORE: begin
               next_listening = saved; // RL14
               next_mask = saved ? MASK_ALL : MASK_NONE;
            end
            default: begin
               if (active) begin
                  next_exec = 1'b1; // RL3
                  case (cmd_code_i)
                     MAF_CMD_SET_ADDR: next_pending = hold_value_i; // RL6
                     MAF_CMD_SAVE: begin
                        next_dev_addr = pending; // RL7
                        next_save_pulse = 1'b1;
                     end
                     MAF_CMD_SET_OUT: if (single_synth_i) next_pin_level = 1'b1; // RL16 RL17
                     MAF_CMD_CLR_OUT: if (single_synth_i) next_pin_level = 1'b0; // RL17
                     MAF_CMD_TOGGLE_OUT: if (single_synth_i) next_pin_level = !pin_level; // RL18
                     MAF_CMD_OPEN_DRAIN: next_open_drain = 1'b1; // RL19
                     MAF_CMD_PUSH_PULL: next_open_drain = 1'b0; // RL19
                     default: next_exec = 1'b1;
                  endcase
               end
            end
         endcase
      end
      // Open drain only drives the low level
      next_pin_oe = next_open_drain ? !next_pin_level : 1'b1; // RL19
   end

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         loaded <= 1'b0;
         listening <= 1'b1;
         saved <= 1'b1;
         dev_addr <= ADDR_UNASSIGNED;
         pending <= ADDR_UNASSIGNED;
         mask <= MASK_ALL;
         exec <= 1'b0;
         save_pulse <= 1'b0;
         text <= 16'h0000;
         pin_level <= 1'b0;
         open_drain <= 1'b0;
         pin_oe <= 1'b1;
      end else begin
         loaded <= 1'b1;
         listening <= next_listening;
         saved <= next_saved;
         dev_addr <= next_dev_addr;
         pending <= next_pending;
         mask <= next_mask;
         exec <= next_exec;
         save_pulse <= next_save_pulse;
         text <= next_text;
         pin_level <= next_pin_level;
         open_drain <= next_open_drain;
         pin_oe <= next_pin_oe;
      end
   end

   assign exec_o = exec;
   assign listening_o = listening;
   assign device_addr_o = dev_addr;
   assign pending_addr_o = pending;
   assign addr_mask_o = mask;
   assign save_store_o = save_pulse;
   assign addr_text_o = text;
   assign spare_output_port_bit_o = pin_level;
   assign spare_output_port_bit_oe_o = pin_oe;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   a_listen_match: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL9
      loaded && cmd_valid_i && cmd_code_i == MAF_CMD_LISTEN && match |=> listening && saved)
      else $error("listen with match did not set listen");

   a_kill_match: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL10
      loaded && cmd_valid_i && cmd_code_i == MAF_CMD_KILL && match |=> !listening && !saved)
      else $error("kill with match did not set ignore");

   a_nomatch_keep: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL9
      loaded && cmd_valid_i && (cmd_code_i == MAF_CMD_LISTEN || cmd_code_i == MAF_CMD_KILL)
      && !match |=> $stable(listening))
      else $error("unmatched listen or kill changed state");

   a_global_force: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL12
      loaded && cmd_valid_i && cmd_code_i == MAF_CMD_GLOBAL |=>
      listening && mask == MASK_ALL && saved == $past(listening))
      else $error("global did not save and force listen");

   a_global_mask: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL20
      loaded && cmd_valid_i && cmd_code_i == MAF_CMD_GLOBAL |=> mask == MASK_ALL)
      else $error("global did not open the address mask");

   a_mask_force: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL13
      loaded && cmd_valid_i && cmd_code_i == MAF_CMD_MASK |=>
      !listening && saved == $past(listening))
      else $error("mask did not save and force ignore");

   a_restore_back: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL14
      loaded && cmd_valid_i && cmd_code_i == MAF_CMD_RESTORE |=> listening == $past(saved))
      else $error("restore did not recover state");

   a_hold_quiet: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL11
      loaded && cmd_valid_i && cmd_code_i == MAF_CMD_HOLD_ENTRY |=> !exec && $stable(listening))
      else $error("holding entry acted on the unit");

   a_ignore_silent: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL21
      !active |=> !exec)
      else $error("ignoring unit executed a command");

   a_listen_exec: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL3
      loaded && listening && cmd_valid_i
      && cmd_code_i inside {MAF_CMD_REPORT, MAF_CMD_OTHER} |=> exec)
      else $error("listening unit did not execute");

   a_unassigned_exec: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL1
      loaded && !addr_assigned_i && cmd_valid_i
      && cmd_code_i inside {MAF_CMD_REPORT, MAF_CMD_OTHER, MAF_CMD_SET_OUT} |=> exec)
      else $error("unassigned unit did not execute");

   // -----------------------------------------------------------------
   // Address checks
   // -----------------------------------------------------------------
   a_load_blank: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL4
      $rose(loaded) && !$past(addr_assigned_i) |-> dev_addr == ADDR_UNASSIGNED)
      else $error("unassigned unit did not read all ones");

   a_load_addr: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL2
      $rose(loaded) && $past(addr_assigned_i) |-> dev_addr == $past(stored_addr_i))
      else $error("stored address not taken at start");

   a_set_addr_pend: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL6
      loaded && active && cmd_valid_i && cmd_code_i == MAF_CMD_SET_ADDR |=>
      pending == $past(hold_value_i) && $stable(dev_addr))
      else $error("set-address touched active address");

   a_save_commit: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL7
      loaded && active && cmd_valid_i && cmd_code_i == MAF_CMD_SAVE |=>
      dev_addr == $past(pending) && save_store_o)
      else $error("save did not commit pending address");

   // -----------------------------------------------------------------
   // Pin checks
   // -----------------------------------------------------------------
   a_set_pin_high: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL17
      loaded && active && single_synth_i && cmd_valid_i && cmd_code_i == MAF_CMD_SET_OUT
      |=> pin_level)
      else $error("set-output did not drive high");

   a_clear_pin_low: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL17
      loaded && active && single_synth_i && cmd_valid_i && cmd_code_i == MAF_CMD_CLR_OUT
      |=> !pin_level)
      else $error("clear-output did not drive low");

   a_toggle_pin: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL18
      loaded && active && single_synth_i && cmd_valid_i && cmd_code_i == MAF_CMD_TOGGLE_OUT
      |=> pin_level != $past(pin_level))
      else $error("toggle did not invert pin");

   a_spare_gated: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL16
      loaded && !single_synth_i && cmd_valid_i
      && cmd_code_i inside {MAF_CMD_SET_OUT, MAF_CMD_CLR_OUT, MAF_CMD_TOGGLE_OUT}
      |=> $stable(pin_level))
      else $error("spare pin moved with two synthesizers");

   a_drain_release: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL19
      open_drain && pin_level |-> !pin_oe)
      else $error("open drain drove a high level");

   a_push_drive: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // RL19
      !(open_drain && pin_level) |-> pin_oe)
      else $error("pin not driven when it should be");
endmodule // maf_address_filter
`default_nettype wire

// *** bench/maf_store_model.sv ***
// Nonvolatile address store behind one drop of the address filter.
// Assumes save strobes on the filter clock; contents survive reset.
`default_nettype none
module maf_store_model (
   // Clock
   input wire logic ref_clk_i,
   // Save request
   input wire logic save_i,
   input wire logic [7:0] pending_addr_i,
   // Stored contents
   output logic assigned_o,
   output logic [7:0] stored_addr_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Blank store: no address, reads all ones
   logic assigned = 1'b0;
   logic [7:0] stored = 8'hFF;
   always @(posedge ref_clk_i) begin
      if (save_i) begin
         assigned <= 1'b1;
         stored <= pending_addr_i;
      end
   end
   assign assigned_o = assigned;
   assign stored_addr_o = stored;
endmodule // maf_store_model
`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking bench for the address filter: reset values, command table, then a mid-run reset.
// Assumes maf_pkg, the filter and the store model are compiled first.
`default_nettype none
module testbench
   import maf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {maf_cmd_t code; logic [7:0] hold; logic [4:0] f;} maf_row_t;
   logic ref_clk_i = 1'b0, resetn_i = 1'b0, cmd_valid_i = 1'b0, single_synth_i = 1'b1;
   maf_cmd_t cmd_code_i = MAF_CMD_NONE;
   logic [7:0] hold_value_i = 8'h00, stored_addr, pending_addr_o, device_addr_o, addr_mask_o;
   logic assigned, exec_o, listening_o, save_store_o, pin_o, oe_o;
   logic [15:0] addr_text_o;
   int num_errors = 0, checked = 0, cycles = 0;
   // Flags: synth single, exec, listening, pin level, pin enable
   maf_row_t rows [22] = '{
      '{MAF_CMD_KILL, 8'h3C, 5'b10011}, '{MAF_CMD_CLR_OUT, 8'h00, 5'b10011},
      '{MAF_CMD_HOLD_ENTRY, 8'h55, 5'b10011}, '{MAF_CMD_LISTEN, 8'h55, 5'b10011},
      '{MAF_CMD_GLOBAL, 8'h00, 5'b10111}, '{MAF_CMD_CLR_OUT, 8'h00, 5'b11101},
      '{MAF_CMD_RESTORE, 8'h00, 5'b10001}, '{MAF_CMD_LISTEN, 8'h3C, 5'b10101},
      '{MAF_CMD_MASK, 8'h00, 5'b10001}, '{MAF_CMD_RESTORE, 8'h00, 5'b10101},
      '{MAF_CMD_GLOBAL, 8'h00, 5'b10101}, '{MAF_CMD_KILL, 8'h3C, 5'b10001},
      '{MAF_CMD_RESTORE, 8'h00, 5'b10001}, '{MAF_CMD_LISTEN, 8'h3C, 5'b10101},
      '{MAF_CMD_SET_OUT, 8'h00, 5'b11111}, '{MAF_CMD_TOGGLE_OUT, 8'h00, 5'b11101},
      '{MAF_CMD_OPEN_DRAIN, 8'h00, 5'b11101}, '{MAF_CMD_TOGGLE_OUT, 8'h00, 5'b11110},
      '{MAF_CMD_PUSH_PULL, 8'h00, 5'b11111}, '{MAF_CMD_TOGGLE_OUT, 8'h00, 5'b01111},
      '{MAF_CMD_REPORT, 8'h00, 5'b11111}, '{MAF_CMD_OTHER, 8'h00, 5'b11111}};
   always #5 ref_clk_i = ~ref_clk_i;
   maf_address_filter maf_address_filter_i (
      .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_i),
      .cmd_code_i(cmd_code_i), .hold_value_i(hold_value_i), .addr_assigned_i(assigned),
      .stored_addr_i(stored_addr), .single_synth_i(single_synth_i), .exec_o(exec_o),
      .listening_o(listening_o), .device_addr_o(device_addr_o),
      .pending_addr_o(pending_addr_o), .addr_mask_o(addr_mask_o),
      .save_store_o(save_store_o), .addr_text_o(addr_text_o),
      .spare_output_port_bit_o(pin_o), .spare_output_port_bit_oe_o(oe_o));
   maf_store_model maf_store_model_i (
      .ref_clk_i(ref_clk_i), .save_i(save_store_o), .pending_addr_i(pending_addr_o),
      .assigned_o(assigned), .stored_addr_o(stored_addr));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One command strobe; returns just after the edge that takes it
   task automatic send(input maf_cmd_t c, input logic [7:0] h, input logic ss = 1'b1);
      @(posedge ref_clk_i);
      cmd_valid_i <= 1'b1;
      cmd_code_i <= c;
      hold_value_i <= h;
      single_synth_i <= ss;
      @(posedge ref_clk_i);
      cmd_valid_i <= 1'b0;
      #1;
   endtask
   task automatic summarize();
      $display("checked=%0d num_errors=%0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         summarize();
      end
   end
   //------------------------------------------
   // Main sequence
   //------------------------------------------
   initial begin
      repeat (8) @(posedge ref_clk_i);
      chk({listening_o, pin_o, oe_o, exec_o}, 4'b1010);
      chk({device_addr_o, addr_mask_o}, {ADDR_UNASSIGNED, MASK_ALL});
      resetn_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      #1;
      chk(addr_text_o, 16'h4646);
      send(MAF_CMD_MASK, 8'h00);
      send(MAF_CMD_SET_OUT, 8'h00);
      chk({exec_o, pin_o}, 2'b11);
      send(MAF_CMD_RESTORE, 8'h00);
      // Only this drop is on the link while its address is set
      send(MAF_CMD_SET_ADDR, 8'h3C);
      chk({pending_addr_o, device_addr_o}, 16'h3CFF);
      send(MAF_CMD_SAVE, 8'h00);
      chk({save_store_o, exec_o, device_addr_o}, 10'h33C);
      @(posedge ref_clk_i);
      #1;
      chk(addr_text_o, 16'h3343);
      foreach (rows[i]) begin
         send(rows[i].code, rows[i].hold, rows[i].f[4]);
         chk(exec_o, rows[i].f[3]);
         chk(listening_o, rows[i].f[2]);
         chk(pin_o, rows[i].f[1]);
         chk(oe_o, rows[i].f[0]);
         if (rows[i].code == MAF_CMD_GLOBAL) chk(addr_mask_o, MASK_ALL);
         if (rows[i].code == MAF_CMD_MASK) chk(addr_mask_o, MASK_NONE);
      end
      // Reset in mid-run: address comes back from the store
      send(MAF_CMD_KILL, 8'h3C);
      resetn_i <= 1'b0;
      #1;
      chk({listening_o, pin_o, oe_o}, 3'b101);
      @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      #1;
      chk(device_addr_o, 8'h3C);
      summarize();
   end
endmodule // testbench
`default_nettype wire
